// *** rtl/bpr_regs.sv ***
// Purpose: refresh period, buffer size code and three 20-bit buffer pointers
// Assumes: register port strobes come from the bus decoder on this clock
// Notes: pointer clears hold as long as the reset source stays active
module bpr_regs (
    // clock and chip reset
    input wire logic I_CLOCK,
    input wire logic I_RESET,
    // register port
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [bpr_pkg::BPR_BYTE_W-1:0] I_REG_WDATA,
    output logic [bpr_pkg::BPR_BYTE_W-1:0] O_REG_RDATA,
    output logic O_REG_RD_ACK,
    // secondary reset sources
    input wire logic I_BUF_RESET,
    input wire logic I_BUS_RESET_N,
    // buffer manager outputs
    output logic O_REFRESH_REQ,
    output logic [bpr_pkg::BPR_PTR_W-1:0] O_DISK_PTR,
    output logic [bpr_pkg::BPR_PTR_W-1:0] O_HOST_PTR,
    output logic [bpr_pkg::BPR_PTR_W-1:0] O_STOP_PTR,
    output logic [bpr_pkg::BPR_BYTE_W-1:0] O_SIZE_CODE,
    output logic O_HOST_AT_STOP
);
    import bpr_pkg::*;

    // bus reset pin synchroniser and agreement filter
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic bus_rst_n;
    logic next_bus_rst_n;

    always_comb begin
        next_bus_rst_n = bus_rst_n;
        // only act once the last two stages agree, so a one-cycle glitch is ignored
        if (pin_s2 == pin_s3) begin
            next_bus_rst_n = pin_s3;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            pin_s1 <= BPR_PIN_IDLE;
            pin_s2 <= BPR_PIN_IDLE;
            pin_s3 <= BPR_PIN_IDLE;
            bus_rst_n <= BPR_PIN_IDLE;
        end else begin
            pin_s1 <= I_BUS_RESET_N;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            bus_rst_n <= next_bus_rst_n;
        end
    end

    // register state
    logic [BPR_BYTE_W-1:0] refresh_period;
    logic [BPR_BYTE_W-1:0] size_code;
    logic [BPR_PTR_W-1:0] disk_ptr;
    logic [BPR_PTR_W-1:0] host_ptr;
    logic [BPR_PTR_W-1:0] stop_ptr;
    logic [BPR_BYTE_W-1:0] next_refresh_period;
    logic [BPR_BYTE_W-1:0] next_size_code;
    logic [BPR_PTR_W-1:0] next_disk_ptr;
    logic [BPR_PTR_W-1:0] next_host_ptr;
    logic [BPR_PTR_W-1:0] next_stop_ptr;

    always_comb begin
        next_refresh_period = refresh_period;
        next_size_code = size_code;
        next_disk_ptr = disk_ptr;
        next_host_ptr = host_ptr;
        next_stop_ptr = stop_ptr;
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                BPR_ADDR_REFRESH: begin
                    next_refresh_period = I_REG_WDATA;
                end
                BPR_ADDR_SIZE: begin
                    next_size_code = I_REG_WDATA;
                end
                BPR_ADDR_DISK_LOW: begin
                    next_disk_ptr[BPR_LOW_LSB +: BPR_BYTE_W] = I_REG_WDATA;
                end
                BPR_ADDR_DISK_MID: begin
                    next_disk_ptr[BPR_MID_LSB +: BPR_BYTE_W] = I_REG_WDATA;
                end
                BPR_ADDR_DISK_HIGH: begin
                    next_disk_ptr[BPR_HIGH_LSB +: BPR_HIGH_W] = I_REG_WDATA[BPR_HIGH_W-1:0];
                end
                BPR_ADDR_HOST_LOW: begin
                    next_host_ptr[BPR_LOW_LSB +: BPR_BYTE_W] = I_REG_WDATA;
                end
                BPR_ADDR_HOST_MID: begin
                    next_host_ptr[BPR_MID_LSB +: BPR_BYTE_W] = I_REG_WDATA;
                end
                BPR_ADDR_HOST_HIGH: begin
                    next_host_ptr[BPR_HIGH_LSB +: BPR_HIGH_W] = I_REG_WDATA[BPR_HIGH_W-1:0];
                end
                BPR_ADDR_STOP_LOW: begin
                    next_stop_ptr[BPR_LOW_LSB +: BPR_BYTE_W] = I_REG_WDATA;
                end
                BPR_ADDR_STOP_MID: begin
                    next_stop_ptr[BPR_MID_LSB +: BPR_BYTE_W] = I_REG_WDATA;
                end
                BPR_ADDR_STOP_HIGH: begin
                    next_stop_ptr[BPR_HIGH_LSB +: BPR_HIGH_W] = I_REG_WDATA[BPR_HIGH_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // resets win over a write in the same cycle; period and size code untouched
        if (I_BUF_RESET) begin
            next_disk_ptr = BPR_RESET_PTR;
            next_host_ptr = BPR_RESET_PTR;
            next_stop_ptr = BPR_RESET_PTR;
        end
        if (!bus_rst_n) begin
            next_host_ptr = BPR_RESET_PTR;
            next_stop_ptr = BPR_RESET_PTR;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            refresh_period <= BPR_RESET_BYTE;
            size_code <= BPR_RESET_BYTE;
            disk_ptr <= BPR_RESET_PTR;
            host_ptr <= BPR_RESET_PTR;
            stop_ptr <= BPR_RESET_PTR;
        end else begin
            refresh_period <= next_refresh_period;
            size_code <= next_size_code;
            disk_ptr <= next_disk_ptr;
            host_ptr <= next_host_ptr;
            stop_ptr <= next_stop_ptr;
        end
    end

    // read path: data registered, answered one cycle after the strobe
    logic [BPR_BYTE_W-1:0] next_rdata;
    logic [BPR_BYTE_W-1:0] rdata;
    logic rd_ack;

    always_comb begin
        next_rdata = rdata;
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                BPR_ADDR_REFRESH: begin
                    next_rdata = refresh_period;
                end
                BPR_ADDR_SIZE: begin
                    next_rdata = size_code;
                end
                BPR_ADDR_DISK_LOW: begin
                    next_rdata = disk_ptr[BPR_LOW_LSB +: BPR_BYTE_W];
                end
                BPR_ADDR_DISK_MID: begin
                    next_rdata = disk_ptr[BPR_MID_LSB +: BPR_BYTE_W];
                end
                BPR_ADDR_DISK_HIGH: begin
                    next_rdata = {BPR_RSVD_HIGH, disk_ptr[BPR_HIGH_LSB +: BPR_HIGH_W]};
                end
                BPR_ADDR_HOST_LOW: begin
                    next_rdata = host_ptr[BPR_LOW_LSB +: BPR_BYTE_W];
                end
                BPR_ADDR_HOST_MID: begin
                    next_rdata = host_ptr[BPR_MID_LSB +: BPR_BYTE_W];
                end
                BPR_ADDR_HOST_HIGH: begin
                    next_rdata = {BPR_RSVD_HIGH, host_ptr[BPR_HIGH_LSB +: BPR_HIGH_W]};
                end
                BPR_ADDR_STOP_LOW: begin
                    next_rdata = stop_ptr[BPR_LOW_LSB +: BPR_BYTE_W];
                end
                BPR_ADDR_STOP_MID: begin
                    next_rdata = stop_ptr[BPR_MID_LSB +: BPR_BYTE_W];
                end
                BPR_ADDR_STOP_HIGH: begin
                    next_rdata = {BPR_RSVD_HIGH, stop_ptr[BPR_HIGH_LSB +: BPR_HIGH_W]};
                end
                default: begin
                    next_rdata = BPR_UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            rdata <= BPR_RESET_BYTE;
            rd_ack <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rd_ack <= I_REG_RD;
        end
    end

    assign O_REG_RDATA = rdata;
    assign O_REG_RD_ACK = rd_ack;
    assign O_DISK_PTR = disk_ptr;
    assign O_HOST_PTR = host_ptr;
    assign O_STOP_PTR = stop_ptr;
    assign O_SIZE_CODE = size_code;

    bpr_refresh_timer #(
        .PERIOD_W(BPR_PERIOD_W)
    ) u_refresh (
        .i_clock(I_CLOCK),
        .i_reset(I_RESET),
        .i_period_hi(refresh_period),
        .o_refresh_req(O_REFRESH_REQ)
    );

    bpr_stop_compare #(
        .PTR_W(BPR_PTR_W),
        .CODE_W(BPR_BYTE_W),
        .FIXED_BITS(BPR_FIXED_CMP_BITS)
    ) u_compare (
        .i_clock(I_CLOCK),
        .i_reset(I_RESET),
        .i_size_code(size_code),
        .i_host_ptr(host_ptr),
        .i_stop_ptr(stop_ptr),
        .o_at_stop(O_HOST_AT_STOP)
    );

    // checks on the register bank
    a_period_readback: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_REFRESH) ##1 !I_REG_WR
            ##1 (I_REG_RD && !I_REG_WR && I_REG_ADDR == BPR_ADDR_REFRESH)
            |=> (O_REG_RD_ACK && O_REG_RDATA == $past(I_REG_WDATA, 3)))
        else $error("refresh period read back differs from last write");

    a_period_kept: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (!I_REG_WR && (I_BUF_RESET || !bus_rst_n)) |=> $stable(refresh_period)
            && $stable(size_code))
        else $error("secondary reset disturbed period or size code");

    a_buf_clears_all: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        I_BUF_RESET |=> (O_DISK_PTR == BPR_RESET_PTR && O_HOST_PTR == BPR_RESET_PTR
            && O_STOP_PTR == BPR_RESET_PTR))
        else $error("pointers not cleared by buffer reset");

    a_bus_clears_host: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (!I_BUS_RESET_N) [*5] |-> ##1 (O_HOST_PTR == BPR_RESET_PTR
            && O_STOP_PTR == BPR_RESET_PTR))
        else $error("host or stop pointer survived bus reset");

    a_bus_spares_disk: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (!bus_rst_n && !I_BUF_RESET && !I_REG_WR) |=> $stable(O_DISK_PTR))
        else $error("bus reset changed disk pointer");

    a_high_rsvd_zero: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_RD && (I_REG_ADDR == BPR_ADDR_DISK_HIGH || I_REG_ADDR == BPR_ADDR_HOST_HIGH
            || I_REG_ADDR == BPR_ADDR_STOP_HIGH))
            |=> (O_REG_RDATA[BPR_BYTE_W-1:BPR_HIGH_W] == BPR_RSVD_HIGH))
        else $error("reserved high bits read nonzero");

    a_disk_mid_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_DISK_MID && !I_BUF_RESET)
            |=> (O_DISK_PTR[BPR_MID_LSB +: BPR_BYTE_W] == $past(I_REG_WDATA)
            && O_DISK_PTR[BPR_LOW_LSB +: BPR_BYTE_W] == $past(disk_ptr[BPR_LOW_LSB +: BPR_BYTE_W])))
        else $error("disk middle byte write wrong or disturbed low byte");

    a_stop_high_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_STOP_HIGH && !I_BUF_RESET && bus_rst_n)
            |=> (O_STOP_PTR[BPR_HIGH_LSB +: BPR_HIGH_W] == $past(I_REG_WDATA[BPR_HIGH_W-1:0])))
        else $error("stop pointer high part not written");

    a_host_low_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_HOST_LOW && !I_BUF_RESET && bus_rst_n)
            |=> (O_HOST_PTR[BPR_LOW_LSB +: BPR_BYTE_W] == $past(I_REG_WDATA)))
        else $error("host pointer low byte not written");

    a_unmapped_zero: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_RD && (I_REG_ADDR < BPR_ADDR_REFRESH || I_REG_ADDR > BPR_ADDR_STOP_HIGH))
            |=> (O_REG_RDATA == BPR_UNMAPPED_READ))
        else $error("unmapped read returned data");

    a_rd_ack_pulse: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        I_REG_RD |=> O_REG_RD_ACK)
        else $error("read not acknowledged one cycle later");

    a_ack_only_read: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        !I_REG_RD |=> !O_REG_RD_ACK)
        else $error("acknowledge raised without a read");

    a_rdata_holds: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        !I_REG_RD |=> $stable(O_REG_RDATA))
        else $error("read data changed without a read");

    a_size_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_SIZE) |=> (O_SIZE_CODE == $past(I_REG_WDATA)))
        else $error("size code not written");

    a_disk_low_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_DISK_LOW && !I_BUF_RESET)
            |=> (O_DISK_PTR[BPR_LOW_LSB +: BPR_BYTE_W] == $past(I_REG_WDATA)))
        else $error("disk pointer low byte not written");

    a_disk_high_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_DISK_HIGH && !I_BUF_RESET)
            |=> (O_DISK_PTR[BPR_HIGH_LSB +: BPR_HIGH_W] == $past(I_REG_WDATA[BPR_HIGH_W-1:0])))
        else $error("disk pointer high part not written");

    a_host_mid_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_HOST_MID && !I_BUF_RESET && bus_rst_n)
            |=> (O_HOST_PTR[BPR_MID_LSB +: BPR_BYTE_W] == $past(I_REG_WDATA)))
        else $error("host pointer middle byte not written");

    a_stop_low_write: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        (I_REG_WR && I_REG_ADDR == BPR_ADDR_STOP_LOW && !I_BUF_RESET && bus_rst_n)
            |=> (O_STOP_PTR[BPR_LOW_LSB +: BPR_BYTE_W] == $past(I_REG_WDATA)))
        else $error("stop pointer low byte not written");

    a_filtered_bus_clear: assert property (
        @(posedge I_CLOCK) disable iff (I_RESET)
        !bus_rst_n |=> (O_HOST_PTR == BPR_RESET_PTR && O_STOP_PTR == BPR_RESET_PTR))
        else $error("pointer written while bus reset active");
endmodule : bpr_regs

// *** rtl/bpr_pkg.sv ***
// Purpose: shared constants of the buffer pointer and refresh register bank
// Assumes: eight-bit register port of the local microcontroller, one clock
// Notes: offsets are the byte addresses of the register port
// Functional notes
// - refresh period register gives upper eight bits; hidden period LSB is always one
// - refresh interval equals the nine-bit period in system clock cycles
// - buffer size code is an eight-bit low-order mask, 00H up to FFH
// - size code selects which pointer bits take part in host/stop compare
// - disk pointer: low, middle and four-bit high part, for disk and controller
// - disk pointer clears on chip reset and on the host/buffer reset bit
// - host pointer: low, middle and four-bit high part, for host transfers
// - host and stop pointers also clear while bus reset input is low
// - stop pointer: low, middle and four-bit high part, for host transfers
// - refresh period and size code clear only on chip reset
// - every register is readable and writable; read returns last written value, but high parts read their upper four bits as zero
package bpr_pkg;
    localparam int BPR_BYTE_W = 8;
    localparam int BPR_HIGH_W = 4;
    localparam int BPR_PTR_W = 20;
    localparam int BPR_PERIOD_W = 9;
    localparam int BPR_FIXED_CMP_BITS = 11;
    localparam int BPR_LOW_LSB = 0;
    localparam int BPR_MID_LSB = 8;
    localparam int BPR_HIGH_LSB = 16;

    localparam logic [7:0] BPR_ADDR_REFRESH = 8'h55;
    localparam logic [7:0] BPR_ADDR_SIZE = 8'h56;
    localparam logic [7:0] BPR_ADDR_DISK_LOW = 8'h57;
    localparam logic [7:0] BPR_ADDR_DISK_MID = 8'h58;
    localparam logic [7:0] BPR_ADDR_DISK_HIGH = 8'h59;
    localparam logic [7:0] BPR_ADDR_HOST_LOW = 8'h5A;
    localparam logic [7:0] BPR_ADDR_HOST_MID = 8'h5B;
    localparam logic [7:0] BPR_ADDR_HOST_HIGH = 8'h5C;
    localparam logic [7:0] BPR_ADDR_STOP_LOW = 8'h5D;
    localparam logic [7:0] BPR_ADDR_STOP_MID = 8'h5E;
    localparam logic [7:0] BPR_ADDR_STOP_HIGH = 8'h5F;

    localparam logic [7:0] BPR_RESET_BYTE = 8'h00;
    localparam logic [19:0] BPR_RESET_PTR = 20'h00000;
    localparam logic [3:0] BPR_RSVD_HIGH = 4'h0;
    localparam logic [7:0] BPR_UNMAPPED_READ = 8'h00;
    localparam logic BPR_PERIOD_LSB = 1'b1;
    localparam logic BPR_PIN_IDLE = 1'b1;
endpackage : bpr_pkg

// *** rtl/bpr_refresh_timer.sv ***
// Purpose: counts system clock cycles and pulses a DRAM refresh request
// Assumes: period upper bits come from a register on the same clock
// Notes: a period shortened mid-count takes effect at once, no long wrap
module bpr_refresh_timer #(
    parameter int PERIOD_W = 9
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // programmed period, upper bits only
    input wire logic [PERIOD_W-2:0] i_period_hi,
    // refresh request
    output logic o_refresh_req
);
    import bpr_pkg::*;

    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] count;
    logic [PERIOD_W-1:0] next_count;
    logic next_req;

    assign period = {i_period_hi, BPR_PERIOD_LSB};

    always_comb begin
        next_count = count + PERIOD_W'(1);
        next_req = 1'b0;
        if (count >= period - PERIOD_W'(1)) begin
            next_count = '0;
            next_req = 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            count <= '0;
            o_refresh_req <= 1'b0;
        end else begin
            count <= next_count;
            o_refresh_req <= next_req;
        end
    end

    // helper: cycles since last request, and whether the period moved meanwhile
    logic [PERIOD_W:0] gap;
    logic seen;
    logic moved;
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            gap <= '0;
            seen <= 1'b0;
            moved <= 1'b0;
        end else begin
            gap <= o_refresh_req ? '0 : gap + (PERIOD_W+1)'(1);
            seen <= seen | o_refresh_req;
            moved <= o_refresh_req ? 1'b0 : (moved | (i_period_hi != $past(i_period_hi)));
        end
    end

    a_refresh_gap_exact: assert property (
        @(posedge i_clock) disable iff (i_reset)
        (o_refresh_req && seen && !moved && $stable(i_period_hi))
            |-> (gap == {1'b0, period} - (PERIOD_W+1)'(1)))
        else $error("refresh interval differs from programmed period");

    a_period_min_one: assert property (
        @(posedge i_clock) disable iff (i_reset)
        (i_period_hi == '0) [*3] |-> o_refresh_req)
        else $error("period of one cycle does not request every cycle");
endmodule : bpr_refresh_timer

// *** rtl/bpr_stop_compare.sv ***
// Purpose: compares host pointer with stop pointer inside the configured buffer
// Assumes: size code is a low-order mask; pointers are on the same clock
// Notes: bits above the largest buffer never take part
module bpr_stop_compare #(
    parameter int PTR_W = 20,
    parameter int CODE_W = 8,
    parameter int FIXED_BITS = 11
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // operands
    input wire logic [CODE_W-1:0] i_size_code,
    input wire logic [PTR_W-1:0] i_host_ptr,
    input wire logic [PTR_W-1:0] i_stop_ptr,
    // result
    output logic o_at_stop
);
    import bpr_pkg::*;

    localparam int TOP_BITS = PTR_W - FIXED_BITS - CODE_W;

    logic [PTR_W-1:0] mask;
    logic next_at_stop;

    assign mask = {{TOP_BITS{1'b0}}, i_size_code, {FIXED_BITS{1'b1}}};

    always_comb begin
        next_at_stop = ((i_host_ptr ^ i_stop_ptr) & mask) == '0;
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_at_stop <= 1'b0;
        end else begin
            o_at_stop <= next_at_stop;
        end
    end

    a_small_buf_match: assert property (
        @(posedge i_clock) disable iff (i_reset)
        (i_size_code == '0 && i_host_ptr[FIXED_BITS-1:0] == i_stop_ptr[FIXED_BITS-1:0])
            |=> o_at_stop)
        else $error("smallest buffer compare looked at upper bits");

    a_low_bits_differ: assert property (
        @(posedge i_clock) disable iff (i_reset)
        (i_host_ptr[FIXED_BITS-1:0] != i_stop_ptr[FIXED_BITS-1:0]) |=> !o_at_stop)
        else $error("stop reported although low bits differ");

    a_full_buf_bit: assert property (
        @(posedge i_clock) disable iff (i_reset)
        (i_size_code == '1 && i_host_ptr[FIXED_BITS+CODE_W-1] != i_stop_ptr[FIXED_BITS+CODE_W-1])
            |=> !o_at_stop)
        else $error("largest buffer compare ignored its top bit");
endmodule : bpr_stop_compare

// *** dv/bpr_mcu_model.sv ***
// Purpose: local microcontroller side of the register port, driven by bench tasks
// Assumes: strobes are one-cycle pulses; read answer comes one edge later
// Notes: idle address and data show the inverse of the last value, never stale data
module bpr_mcu_model (
    // clock
    input wire logic i_clock,
    // register port
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_rd_ack
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clock) #1;
        o_reg_wr = 1'b1;
        o_reg_addr = addr;
        o_reg_wdata = data;
        @(posedge i_clock) #1;
        o_reg_wr = 1'b0;
        o_reg_addr = ~addr;
        o_reg_wdata = ~data;
    endtask : wr_reg

    // answer is taken at the edge after the strobe, as the port promises
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic ack);
        @(posedge i_clock) #1;
        o_reg_rd = 1'b1;
        o_reg_addr = addr;
        @(posedge i_clock) #1;
        data = i_reg_rdata;
        ack = i_reg_rd_ack;
        o_reg_rd = 1'b0;
        o_reg_addr = ~addr;
    endtask : rd_reg
endmodule : bpr_mcu_model

// *** dv/tb_buffer_pointer_refresh_regs.sv ***
// Purpose: self-checking bench of the pointer, size and refresh register bank
// Assumes: 100 MHz clock; inputs change 1 ns after the rising edge
// Notes: register rows first, then refresh, compare and reset cases by hand
module tb_buffer_pointer_refresh_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import bpr_pkg::*;

    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_buf_reset = 1'b0;
    logic i_bus_reset_n = 1'b1;
    logic reg_wr, reg_rd, rd_ack, refresh_req, at_stop;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, size_code, rdat;
    logic [19:0] disk_ptr, host_ptr, stop_ptr;
    logic ack;
    int num_errors = 0;
    int total_checks = 0;
    int gap;
    logic [7:0] row_addr [12] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A,
                                   8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h60};
    logic [7:0] row_data [12] = '{8'hA5, 8'h7F, 8'h12, 8'h34, 8'hF6, 8'h56,
                                   8'h78, 8'hE9, 8'h9A, 8'hBC, 8'hFD, 8'hFF};
    logic [7:0] row_exp [12] = '{8'hA5, 8'h7F, 8'h12, 8'h34, 8'h06, 8'h56,
                                  8'h78, 8'h09, 8'h9A, 8'hBC, 8'h0D, 8'h00};

    always #5 i_clock = ~i_clock;

    bpr_regs u_dut (
        .I_CLOCK(i_clock),
        .I_RESET(i_reset),
        .I_REG_WR(reg_wr),
        .I_REG_RD(reg_rd),
        .I_REG_ADDR(reg_addr),
        .I_REG_WDATA(reg_wdata),
        .O_REG_RDATA(reg_rdata),
        .O_REG_RD_ACK(rd_ack),
        .I_BUF_RESET(i_buf_reset),
        .I_BUS_RESET_N(i_bus_reset_n),
        .O_REFRESH_REQ(refresh_req),
        .O_DISK_PTR(disk_ptr),
        .O_HOST_PTR(host_ptr),
        .O_STOP_PTR(stop_ptr),
        .O_SIZE_CODE(size_code),
        .O_HOST_AT_STOP(at_stop)
    );

    bpr_mcu_model u_mcu (
        .i_clock(i_clock),
        .o_reg_wr(reg_wr),
        .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata),
        .i_reg_rdata(reg_rdata),
        .i_reg_rd_ack(rd_ack)
    );

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
        u_mcu.rd_reg(addr, rdat, ack);
        check({19'h0, ack}, 20'h00001);
        check({12'h0, rdat}, {12'h0, exp});
    endtask : rd_check

    // cycles between two refresh pulses; bounded so a dead timer cannot hang
    task automatic measure(output int n);
        int k;
        n = 0;
        for (k = 0; k < 1200 && refresh_req !== 1'b1; k++) @(posedge i_clock) #1;
        do begin
            @(posedge i_clock) #1;
            n++;
        end while (refresh_req !== 1'b1 && n < 1200);
    endtask : measure

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #200us;
        num_errors++;
        results();
    end

    initial begin
        repeat (8) @(posedge i_clock);
        #1 i_reset = 1'b0;
        for (int r = 0; r < 12; r++) begin
            u_mcu.wr_reg(row_addr[r], row_data[r]);
            rd_check(row_addr[r], row_exp[r]);
        end
        check(disk_ptr, 20'h63412);
        check(host_ptr, 20'h97856);
        check(stop_ptr, 20'hDBC9A);
        check({12'h0, size_code}, 20'h0007F);
        $display("test register rows done");

        measure(gap);
        check(20'(gap), 20'h0014B);
        u_mcu.wr_reg(BPR_ADDR_REFRESH, 8'h01);
        measure(gap);
        check(20'(gap), 20'h00003);
        u_mcu.wr_reg(BPR_ADDR_REFRESH, 8'h00);
        measure(gap);
        check(20'(gap), 20'h00001);
        $display("test refresh period done");

        // host and stop differ only in address bit 11
        u_mcu.wr_reg(BPR_ADDR_SIZE, 8'h00);
        u_mcu.wr_reg(BPR_ADDR_HOST_LOW, 8'h00);
        u_mcu.wr_reg(BPR_ADDR_HOST_MID, 8'h08);
        u_mcu.wr_reg(BPR_ADDR_HOST_HIGH, 8'h00);
        u_mcu.wr_reg(BPR_ADDR_STOP_LOW, 8'h00);
        u_mcu.wr_reg(BPR_ADDR_STOP_MID, 8'h00);
        u_mcu.wr_reg(BPR_ADDR_STOP_HIGH, 8'h00);
        repeat (2) @(posedge i_clock) #1;
        check({19'h0, at_stop}, 20'h00001);
        u_mcu.wr_reg(BPR_ADDR_SIZE, 8'h01);
        repeat (2) @(posedge i_clock) #1;
        check({19'h0, at_stop}, 20'h00000);
        u_mcu.wr_reg(BPR_ADDR_SIZE, 8'hFF);
        u_mcu.wr_reg(BPR_ADDR_STOP_MID, 8'h08);
        u_mcu.wr_reg(BPR_ADDR_STOP_HIGH, 8'h08);
        repeat (2) @(posedge i_clock) #1;
        check({19'h0, at_stop}, 20'h00001);
        // bit 18 lies inside the largest buffer and must still count
        u_mcu.wr_reg(BPR_ADDR_STOP_HIGH, 8'h0C);
        repeat (2) @(posedge i_clock) #1;
        check({19'h0, at_stop}, 20'h00000);
        $display("test stop compare done");

        // bus reset leaves the disk pointer alone
        u_mcu.wr_reg(BPR_ADDR_DISK_LOW, 8'h5A);
        @(posedge i_clock) #1 i_bus_reset_n = 1'b0;
        repeat (8) @(posedge i_clock) #1;
        check(host_ptr, 20'h00000);
        check(stop_ptr, 20'h00000);
        check(disk_ptr, 20'h6345A);
        i_bus_reset_n = 1'b1;
        repeat (6) @(posedge i_clock) #1;
        u_mcu.wr_reg(BPR_ADDR_HOST_LOW, 8'h11);
        check(host_ptr, 20'h00011);
        // a one-cycle low on the bus reset pin is filtered out
        i_bus_reset_n = 1'b0;
        @(posedge i_clock) #1 i_bus_reset_n = 1'b1;
        repeat (6) @(posedge i_clock) #1;
        check(host_ptr, 20'h00011);
        $display("test bus reset done");

        i_buf_reset = 1'b1;
        @(posedge i_clock) #1 i_buf_reset = 1'b0;
        check(disk_ptr, 20'h00000);
        check(host_ptr, 20'h00000);
        rd_check(BPR_ADDR_SIZE, 8'hFF);
        rd_check(BPR_ADDR_REFRESH, 8'h00);
        u_mcu.wr_reg(BPR_ADDR_REFRESH, 8'h3C);
        $display("test buffer reset done");

        #1 i_reset = 1'b1;
        repeat (2) @(posedge i_clock) #1;
        i_reset = 1'b0;
        rd_check(BPR_ADDR_REFRESH, 8'h00);
        rd_check(BPR_ADDR_SIZE, 8'h00);
        check(stop_ptr, 20'h00000);
        $display("test chip reset done");
        results();
    end
endmodule : tb_buffer_pointer_refresh_regs
